// ---- hw/qlp_consts.svh ----
// Constants for the four-lane double-data-rate parallel port.
// Assumes inclusion by bare name from the package and modules.
`ifndef QLP_CONSTS_SVH
`define QLP_CONSTS_SVH
`define QLP_LANES        4
`define QLP_WORD_W       10
`define QLP_BYTE_W       8
`define QLP_BIT_KCHAR    8
`define QLP_BIT_NINE     9
`define QLP_ADDR_CTRL    32'h0000_0000
`define QLP_ADDR_STATUS  32'h0000_0004
`define QLP_ADDR_TXSEEN  32'h0000_0008
`define QLP_ADDR_RXWORD  32'h0000_000c
`define QLP_CTRL_RESET   2'h0
`define QLP_CTRL_SYNC    0
`define QLP_CTRL_CODE    1
`endif

// ---- hw/qlp_pkg.sv ----
// Types shared by the parallel port modules.
// Assumes qlp_consts.svh is on the include path.
`include "qlp_consts.svh"
package qlp_pkg;
  typedef logic [`QLP_WORD_W-1:0] qlp_word_t;
  typedef struct packed {
    logic                   kchar;
    logic [`QLP_BYTE_W-1:0] data;
  } qlp_char_t;
  typedef struct packed {
    logic lane_sync_select;
    logic kchar_generate;
  } qlp_cfg_t;
endpackage : qlp_pkg

// ---- hw/qlp_sync2.sv ----
// Two-flop level synchroniser.
// Assumes the input is asynchronous to clk_i.
`timescale 1ns/10ps
module qlp_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] q_reg;
  always_ff @(posedge clk_i) begin
    meta_reg <= d_i;
    q_reg    <= meta_reg;
  end
  assign q_o = q_reg;
endmodule : qlp_sync2

// ---- hw/qlp_ddr_lane.sv ----
// One lane: DDR capture of a transmit word and DDR launch of a receive word.
// Assumes the caller selects the lane clocks per lane sync mode.
`timescale 1ns/10ps
module qlp_ddr_lane
  import qlp_pkg::*;
(
  input  wire logic      tx_clk_i,
  input  wire logic      rx_clk_i,
  input  wire qlp_word_t tx_pin_i,
  input  wire qlp_word_t rx_rise_i,
  input  wire qlp_word_t rx_fall_i,
  output qlp_word_t      tx_rise_o,
  output qlp_word_t      tx_fall_o,
  output qlp_word_t      rx_pin_o
);
  qlp_word_t tx_rise_reg;
  qlp_word_t tx_fall_reg;
  qlp_word_t rx_rise_reg;
  qlp_word_t rx_fall_reg;
  always_ff @(posedge tx_clk_i) begin
    tx_rise_reg <= tx_pin_i;
  end
  always_ff @(negedge tx_clk_i) begin
    tx_fall_reg <= tx_pin_i;
  end
  always_ff @(posedge rx_clk_i) begin
    rx_rise_reg <= rx_rise_i;
  end
  always_ff @(negedge rx_clk_i) begin
    rx_fall_reg <= rx_fall_i;
  end
  assign tx_rise_o = tx_rise_reg;
  assign tx_fall_o = tx_fall_reg;
  // Half-cycle mux: rising half shows the rise word, falling half the fall word
  assign rx_pin_o  = rx_clk_i ? rx_rise_reg : rx_fall_reg;
endmodule : qlp_ddr_lane

// ---- hw/qlp_parallel_port.sv ----
// Four-lane DDR parallel port with 8b/10b pass or char mode and a Wishbone view.
// Assumes the serializer and code tables outside; lane clocks are source clocks.
//
// The placing of the registers and the Wishbone slave port were decided locally.
`timescale 1ns/10ps
`include "qlp_consts.svh"
// Function
// - Sync off: lanes B-D rx per own clock
// - Sync on: lanes B-D rx on lane A clock
// - Raw mode: rx bit 8 is code bit nine
// - Char mode: rx bit 8 flags K-character
// - Raw mode: rx bit 9 is code bit ten
// - Char mode: rx bit 9 flags decode error
// - Bits 8-9 clocked like their byte
// - Lane A tx captured both edges
// - Char mode: tx bit 8 requests K-character
// - Tx bit 9 raw bit, ignored in char mode
// - Sync off: lanes B-D tx per own clock
// - Sync on: lanes B-D tx on lane A clock
// - Codec active only while generate enabled
// - Sync on: rx clocks B-D held low
module qlp_parallel_port
  import qlp_pkg::*;
(
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  input  wire logic [31:0]           wb_adr_i,
  input  wire logic [31:0]           wb_dat_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic                  wb_we_i,
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  input  wire logic                  lane_sync_select_i,
  input  wire logic                  kchar_generate_i,
  input  wire logic                  rx_clock_lane_a_i,
  output logic                       rx_clock_lane_b_o,
  output logic                       rx_clock_lane_c_o,
  output logic                       rx_clock_lane_d_o,
  input  wire logic                  rx_clock_lane_b_i,
  input  wire logic                  rx_clock_lane_c_i,
  input  wire logic                  rx_clock_lane_d_i,
  input  wire logic                  tx_clock_lane_a_i,
  input  wire logic                  tx_clock_lane_b_i,
  input  wire logic                  tx_clock_lane_c_i,
  input  wire logic                  tx_clock_lane_d_i,
  input  wire qlp_word_t             tx_word_lane_a_i,
  input  wire qlp_word_t             tx_word_lane_b_i,
  input  wire qlp_word_t             tx_word_lane_c_i,
  input  wire qlp_word_t             tx_word_lane_d_i,
  input  wire qlp_word_t             rx_code_lane_b_i,
  input  wire qlp_word_t             rx_code_lane_c_i,
  input  wire qlp_word_t             rx_code_lane_d_i,
  input  wire logic [2:0]            rx_kchar_valid_i,
  input  wire logic [2:0]            rx_code_error_i,
  output qlp_word_t                  rx_word_lane_b_o,
  output qlp_word_t                  rx_word_lane_c_o,
  output qlp_word_t                  rx_word_lane_d_o,
  output qlp_char_t [3:0]            tx_char_rise_o,
  output qlp_char_t [3:0]            tx_char_fall_o,
  output logic      [3:0][1:0]       tx_raw_ninth_o,
  output logic                       codec_enable_o
);
  typedef enum logic [1:0] {QLP_IDLE, QLP_ACK} qlp_wb_state_t;

  // Receive word builder: raw code, or char byte with flag and error
  function automatic qlp_word_t rx_compose(input qlp_word_t code, input logic code_en,
                                           input logic kflag, input logic err);
    qlp_word_t w;
    w = code;
    if (code_en) begin
      w[`QLP_BIT_KCHAR] = kflag;
      w[`QLP_BIT_NINE]  = err;
    end
    return w;
  endfunction : rx_compose

  // Lane clock choice: lane A clock while lanes run in sync
  function automatic logic lane_clk(input logic sync, input logic clk_a, input logic clk_own);
    logic c;
    c = sync ? clk_a : clk_own;
    return c;
  endfunction : lane_clk

  // Receive clock output: held low while lanes run in sync
  function automatic logic rx_clk_out(input logic sync, input logic clk_own);
    logic c;
    c = sync ? 1'b0 : clk_own;
    return c;
  endfunction : rx_clk_out

  // Bit 8 is the K request in char mode and code bit nine in raw mode
  function automatic qlp_char_t tx_char(input qlp_word_t w);
    qlp_char_t c;
    c.data  = w[`QLP_BYTE_W-1:0];
    c.kchar = w[`QLP_BIT_KCHAR];
    return c;
  endfunction : tx_char

  // Bit 9 is code bit ten in raw mode and ignored in char mode
  function automatic logic tx_ninth(input qlp_word_t w, input logic code_en);
    logic b;
    b = code_en ? 1'b0 : w[`QLP_BIT_NINE];
    return b;
  endfunction : tx_ninth

  // Register read decode; unmapped offsets read as zero
  function automatic logic [31:0] reg_read(input logic [31:0] adr, input logic [1:0] ctrl,
                                           input logic [1:0] status, input logic [3:0] seen, input qlp_word_t rxw);
    logic [31:0] r;
    case (adr)
      `QLP_ADDR_CTRL:   r = {30'h0, ctrl};
      `QLP_ADDR_STATUS: r = {30'h0, status};
      `QLP_ADDR_TXSEEN: r = {28'h0, seen};
      `QLP_ADDR_RXWORD: r = {22'h0, rxw};
      default:          r = 32'h0000_0000;
    endcase
    return r;
  endfunction : reg_read

  // Mode pins are asynchronous straps, synchronised to clk_i for status
  logic [1:0] mode_sync;
  qlp_sync2 #(.W(2)) u_mode_sync (
    .clk_i (clk_i),
    .d_i   ({kchar_generate_i, lane_sync_select_i}),
    .q_o   (mode_sync)
  );

  // Mode pins steer the link side directly; they are static
  logic code_en;
  assign code_en        = kchar_generate_i;
  assign codec_enable_o = code_en;

  // Lane clock selection
  logic [3:0] tx_clk;
  logic [3:0] rx_clk;
  assign tx_clk[0] = tx_clock_lane_a_i;
  assign tx_clk[1] = lane_clk(lane_sync_select_i, tx_clock_lane_a_i, tx_clock_lane_b_i);
  assign tx_clk[2] = lane_clk(lane_sync_select_i, tx_clock_lane_a_i, tx_clock_lane_c_i);
  assign tx_clk[3] = lane_clk(lane_sync_select_i, tx_clock_lane_a_i, tx_clock_lane_d_i);
  assign rx_clk[0] = rx_clock_lane_a_i;
  assign rx_clk[1] = lane_clk(lane_sync_select_i, rx_clock_lane_a_i, rx_clock_lane_b_i);
  assign rx_clk[2] = lane_clk(lane_sync_select_i, rx_clock_lane_a_i, rx_clock_lane_c_i);
  assign rx_clk[3] = lane_clk(lane_sync_select_i, rx_clock_lane_a_i, rx_clock_lane_d_i);

  assign rx_clock_lane_b_o = rx_clk_out(lane_sync_select_i, rx_clock_lane_b_i);
  assign rx_clock_lane_c_o = rx_clk_out(lane_sync_select_i, rx_clock_lane_c_i);
  assign rx_clock_lane_d_o = rx_clk_out(lane_sync_select_i, rx_clock_lane_d_i);

  qlp_word_t [3:0] tx_pin;
  qlp_word_t [3:0] rx_code;
  qlp_word_t [3:0] rx_word;
  qlp_word_t [3:0] tx_rise;
  qlp_word_t [3:0] tx_fall;
  logic      [3:0] kv;
  logic      [3:0] er;
  assign tx_pin  = {tx_word_lane_d_i, tx_word_lane_c_i, tx_word_lane_b_i, tx_word_lane_a_i};
  assign rx_code = {rx_code_lane_d_i, rx_code_lane_c_i, rx_code_lane_b_i, `QLP_WORD_W'h000};
  assign kv      = {rx_kchar_valid_i, 1'b0};
  assign er      = {rx_code_error_i, 1'b0};

  // Lane A receive pins lie elsewhere; lane 0 here handles only transmit
  for (genvar g = 0; g < `QLP_LANES; g++) begin : g_lane
    qlp_word_t rx_in;
    assign rx_in = rx_compose(rx_code[g], code_en, kv[g], er[g]);
    qlp_ddr_lane u_lane (
      .tx_clk_i  (tx_clk[g]),
      .rx_clk_i  (rx_clk[g]),
      .tx_pin_i  (tx_pin[g]),
      .rx_rise_i (rx_in),
      .rx_fall_i (rx_in),
      .tx_rise_o (tx_rise[g]),
      .tx_fall_o (tx_fall[g]),
      .rx_pin_o  (rx_word[g])
    );
    // Char mode: bit 8 marks a K-character; raw mode: bit 8 is code bit nine
    assign tx_char_rise_o[g] = tx_char(tx_rise[g]);
    assign tx_char_fall_o[g] = tx_char(tx_fall[g]);
    // Raw mode: bit 9 passes as the top of the code word; char mode drops it
    assign tx_raw_ninth_o[g][0] = tx_ninth(tx_rise[g], code_en);
    assign tx_raw_ninth_o[g][1] = tx_ninth(tx_fall[g], code_en);
  end

  assign rx_word_lane_b_o = rx_word[1];
  assign rx_word_lane_c_o = rx_word[2];
  assign rx_word_lane_d_o = rx_word[3];

  // Transmit activity seen per lane: toggle in link domain, sync into clk_i
  // Link clocks rest while rst_i is high, so the toggles take it asynchronously
  logic [3:0] tx_tog;
  logic [3:0] tx_tog_s;
  logic [3:0] tx_tog_d_reg;
  logic [3:0] tx_tog_d_next;
  for (genvar g = 0; g < `QLP_LANES; g++) begin : g_tog
    logic tog_reg;
    logic tog_next;
    always_comb begin
      tog_next = ~tog_reg;
    end
    always_ff @(posedge tx_clk[g] or posedge rst_i) begin
      if (rst_i) begin
        tog_reg <= 1'b0;
      end else begin
        tog_reg <= tog_next;
      end
    end
    assign tx_tog[g] = tog_reg;
  end
  qlp_sync2 #(.W(4)) u_tog_sync (
    .clk_i (clk_i),
    .d_i   (tx_tog),
    .q_o   (tx_tog_s)
  );

  // Lane B raw word to the register side: toggle handshake, one word per round trip.
  // The link side loads the hold register only on a new request and answers by toggling
  // its acknowledge; the register side copies the hold register once the answer is in,
  // so the word never changes while clk_i samples it.
  logic      rxw_req_reg;
  logic      rxw_req_next;
  qlp_word_t rxw_snap_reg;
  qlp_word_t rxw_snap_next;
  logic      rxw_ack_s;
  logic      rxw_req_l;
  logic      rxw_ack_reg;
  logic      rxw_ack_next;
  qlp_word_t rxw_hold_reg;
  qlp_word_t rxw_hold_next;

  // Register side: a new request as soon as the last one is answered
  always_comb begin
    rxw_req_next  = rxw_req_reg;
    rxw_snap_next = rxw_snap_reg;
    if (rxw_ack_s == rxw_req_reg) begin
      rxw_snap_next = rxw_hold_reg;
      rxw_req_next  = ~rxw_req_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rxw_req_reg  <= 1'b0;
      rxw_snap_reg <= `QLP_WORD_W'h000;
    end else begin
      rxw_req_reg  <= rxw_req_next;
      rxw_snap_reg <= rxw_snap_next;
    end
  end

  qlp_sync2 #(.W(1)) u_req_sync (
    .clk_i (rx_clk[1]),
    .d_i   (rxw_req_reg),
    .q_o   (rxw_req_l)
  );

  // Link side: take the word once per request, then answer
  always_comb begin
    rxw_ack_next  = rxw_ack_reg;
    rxw_hold_next = rxw_hold_reg;
    if (rxw_req_l != rxw_ack_reg) begin
      rxw_hold_next = rx_code_lane_b_i;
      rxw_ack_next  = rxw_req_l;
    end
  end

  // Lane B clock rests during reset, hence the asynchronous clear
  always_ff @(posedge rx_clk[1] or posedge rst_i) begin
    if (rst_i) begin
      rxw_ack_reg  <= 1'b0;
      rxw_hold_reg <= `QLP_WORD_W'h000;
    end else begin
      rxw_ack_reg  <= rxw_ack_next;
      rxw_hold_reg <= rxw_hold_next;
    end
  end

  qlp_sync2 #(.W(1)) u_ack_sync (
    .clk_i (clk_i),
    .d_i   (rxw_ack_reg),
    .q_o   (rxw_ack_s)
  );

  // Register state
  logic [1:0]  ctrl_reg;
  logic [1:0]  ctrl_next;
  logic [3:0]  seen_reg;
  logic [3:0]  seen_next;
  logic [31:0] dat_reg;
  logic [31:0] dat_next;
  qlp_wb_state_t st_reg;
  qlp_wb_state_t st_next;
  logic        hit;
  logic        w1c;

  assign hit = wb_cyc_i & wb_stb_i & (st_reg == QLP_IDLE);
  assign w1c = hit & wb_we_i & (wb_adr_i == `QLP_ADDR_TXSEEN) & wb_sel_i[0];

  always_comb begin
    ctrl_next     = ctrl_reg;
    dat_next      = dat_reg;
    st_next       = st_reg;
    tx_tog_d_next = tx_tog_s;
    // Lane seen bit: set wins over a simultaneous clear
    seen_next = seen_reg & ~(w1c ? wb_dat_i[3:0] : 4'h0);
    seen_next = seen_next | (tx_tog_s ^ tx_tog_d_reg);
    case (st_reg)
      QLP_IDLE: begin
        if (hit) begin
          st_next  = QLP_ACK;
          dat_next = 32'h0000_0000;
          if (wb_we_i) begin
            if (wb_adr_i == `QLP_ADDR_CTRL && wb_sel_i[0]) begin
              ctrl_next = wb_dat_i[1:0];
            end
          end else begin
            dat_next = reg_read(wb_adr_i, ctrl_reg, mode_sync, seen_reg, rxw_snap_reg);
          end
        end
      end
      QLP_ACK: begin
        st_next = QLP_IDLE;
      end
      default: begin
        st_next = QLP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg     <= `QLP_CTRL_RESET;
      seen_reg     <= 4'h0;
      dat_reg      <= 32'h0000_0000;
      st_reg       <= QLP_IDLE;
      tx_tog_d_reg <= 4'h0;
    end else begin
      ctrl_reg     <= ctrl_next;
      seen_reg     <= seen_next;
      dat_reg      <= dat_next;
      st_reg       <= st_next;
      tx_tog_d_reg <= tx_tog_d_next;
    end
  end

  assign wb_ack_o = (st_reg == QLP_ACK);
  assign wb_dat_o = dat_reg;
endmodule : qlp_parallel_port

// ---- testbench/qlp_port_checker.sv ----
// Checker: bus handshake, mode pins and lane A capture of the parallel port.
// Assumes it is bound into qlp_parallel_port and sees only its ports.
`timescale 1ns/10ps
module qlp_port_checker
  import qlp_pkg::*;
(
  input wire logic            clk_i,
  input wire logic            rst_i,
  input wire logic            wb_cyc_i,
  input wire logic            wb_stb_i,
  input wire logic            wb_ack_o,
  input wire logic            lane_sync_select_i,
  input wire logic            kchar_generate_i,
  input wire logic            codec_enable_o,
  input wire logic            rx_clock_lane_b_i,
  input wire logic            rx_clock_lane_b_o,
  input wire logic            rx_clock_lane_c_o,
  input wire logic            rx_clock_lane_d_o,
  input wire logic            tx_clock_lane_a_i,
  input wire qlp_word_t       tx_word_lane_a_i,
  input wire qlp_char_t [3:0] tx_char_rise_o,
  input wire logic [3:0][1:0] tx_raw_ninth_o
);
  qlp_word_t a_q;
  logic      seen_q = 1'b0;
  // Lane A word as launched at the rising edge
  always_ff @(posedge tx_clock_lane_a_i) begin
    a_q    <= tx_word_lane_a_i;
    seen_q <= 1'b1;
  end
  a_codec_follows: assert property (@(posedge clk_i) disable iff (rst_i) codec_enable_o == kchar_generate_i)
    else $error("codec enable wrong");
  a_rxclk_held: assert property (@(posedge clk_i) disable iff (rst_i)
    lane_sync_select_i |-> {rx_clock_lane_b_o, rx_clock_lane_c_o, rx_clock_lane_d_o} == 3'h0) else $error("rx clock out");
  a_rxclk_copy: assert property (@(posedge clk_i) disable iff (rst_i)
    !lane_sync_select_i |-> rx_clock_lane_b_o == rx_clock_lane_b_i) else $error("rx clock copy");
  a_ack_single: assert property (@(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  a_ack_answer: assert property (@(posedge clk_i) disable iff (rst_i) $rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
    else $error("ack late");
  a_ack_cause: assert property (@(posedge clk_i) disable iff (rst_i) wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack unasked");
  a_tx_rise_char: assert property (@(negedge tx_clock_lane_a_i) disable iff (!seen_q)
    tx_char_rise_o[0] == {a_q[8], a_q[7:0]}) else $error("lane a char");
  a_ninth_char: assert property (@(negedge tx_clock_lane_a_i) disable iff (!seen_q)
    kchar_generate_i |-> tx_raw_ninth_o[0][1] == 1'b0) else $error("ninth bit in char mode");
  c_sync_code: cover property (@(posedge clk_i) lane_sync_select_i && codec_enable_o);
  c_ack: cover property (@(posedge clk_i) wb_ack_o);
  c_char_tx: cover property (@(negedge tx_clock_lane_a_i) seen_q && kchar_generate_i && a_q[8]);
endmodule : qlp_port_checker

bind qlp_parallel_port qlp_port_checker u_chk (.*);

// ---- testbench/qlp_mac_model.sv ----
// MAC model: launches lane words and runs link clocks only within frames.
// Assumes run_i opens a frame; lane B-D clocks lag lane A and rest low in sync mode.
`timescale 1ns/10ps
module qlp_mac_model
  import qlp_pkg::*;
(
  input  wire logic  run_i,
  input  wire logic  sync_i,
  output logic       tca_o,
  output logic       tco_o,
  output logic       rca_o,
  output logic       rco_o,
  output qlp_word_t  tw_o [4],
  output qlp_word_t  rw_o [3],
  output logic [5:0] flag_o
);
  logic ts = 1'b0;
  logic rs = 1'b0;
  wire  tgo;
  wire  rgo;
  assign #1.3 tgo = run_i;
  assign #2.7 rgo = run_i;
  assign tco_o = sync_i ? 1'b0 : ts;
  assign rco_o = sync_i ? 1'b0 : rs;
  initial begin
    {tca_o, rca_o, flag_o} = '0;
    tw_o = '{default: '0};
    rw_o = '{default: '0};
  end
  // A clock finishes its cycle after the frame closes, then rests low
  always begin
    wait (tgo || tca_o);
    #62.5 tca_o = !tca_o;
  end
  always begin
    wait (rgo || rca_o);
    #62.5 rca_o = !rca_o;
  end
  always @(tca_o) ts <= #40 tca_o;
  always @(rca_o) rs <= #40 rca_o;
  // New words between edges, so each capture edge sees settled data
  always @(tca_o) begin
    #31;
    foreach (tw_o[l]) tw_o[l] = qlp_word_t'($urandom);
  end
  always @(rca_o) begin
    #31;
    foreach (rw_o[l]) rw_o[l] = qlp_word_t'($urandom);
    flag_o = 6'($urandom);
  end
endmodule : qlp_mac_model

// ---- testbench/tb.sv ----
// Bench: Wishbone register checks, then lane checks in all four modes.
// Assumes the bound checker and the MAC model on the lane side.
`timescale 1ns/10ps
`include "qlp_consts.svh"
module tb;
  import qlp_pkg::*;
  logic            clk_i = 1'b0, rst_i = 1'b0, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic            sync = 1'b0, code = 1'b0, run = 1'b0, wb_ack_o, codec_enable_o, tx_clock_lane_a, tco, rx_clock_lane_a, rco;
  logic [31:0]     wb_adr_i = '0, wb_dat_i = '0, wb_dat_o, rnd;
  logic [3:0]      wb_sel_i = 4'hf;
  logic [5:0]      flag;
  logic [32:0]     nt;
  logic [32:0]     q [$];
  qlp_char_t [3:0] tx_char_rise_o, tx_char_fall_o;
  logic [3:0][1:0] tx_raw_ninth_o;
  qlp_word_t       tw [4];
  qlp_word_t       rw [3];
  qlp_word_t       ro [3];
  int              err_total = 0, n_tests = 0, cyc_cnt = 0;
  qlp_parallel_port dut (.*, .lane_sync_select_i(sync), .kchar_generate_i(code), .rx_clock_lane_a_i(rx_clock_lane_a),
    .rx_clock_lane_b_o(), .rx_clock_lane_c_o(), .rx_clock_lane_d_o(), .rx_clock_lane_b_i(rco),
    .rx_clock_lane_c_i(rco), .rx_clock_lane_d_i(rco), .tx_clock_lane_a_i(tx_clock_lane_a), .tx_clock_lane_b_i(tco),
    .tx_clock_lane_c_i(tco), .tx_clock_lane_d_i(tco), .tx_word_lane_a_i(tw[0]), .tx_word_lane_b_i(tw[1]),
    .tx_word_lane_c_i(tw[2]), .tx_word_lane_d_i(tw[3]), .rx_code_lane_b_i(rw[0]), .rx_code_lane_c_i(rw[1]),
    .rx_code_lane_d_i(rw[2]), .rx_kchar_valid_i(flag[2:0]), .rx_code_error_i(flag[5:3]),
    .rx_word_lane_b_o(ro[0]), .rx_word_lane_c_o(ro[1]), .rx_word_lane_d_o(ro[2]));
  qlp_mac_model mac (.run_i(run), .sync_i(sync), .tca_o(tx_clock_lane_a), .tco_o(tco), .rca_o(rx_clock_lane_a), .rco_o(rco),
    .tw_o(tw), .rw_o(rw), .flag_o(flag));
  initial forever #2.5 clk_i = !clk_i;
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  // Classic single cycle; the read expectation is queued for the monitor
  task automatic wb(input logic we, input logic [31:0] a, input logic [31:0] d, input logic [31:0] e);
    q.push_back({!we, e});
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge clk_i iff wb_ack_o === 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic ctx(input int l, input logic r);
    qlp_word_t w;
    w = tw[l];
    #1;
    chk(32'({r ? tx_char_rise_o[l] : tx_char_fall_o[l], tx_raw_ninth_o[l][!r]}),
        32'({w[8], w[7:0], !code & w[9]}));
  endtask : ctx
  task automatic crx(input int l);
    qlp_word_t e;
    e = code ? {flag[l+3], flag[l], rw[l][7:0]} : rw[l];
    #1;
    chk(32'(ro[l]), 32'(e));
  endtask : crx
  always @(tx_clock_lane_a) if (run) for (int l = 0; l < 4; l++) if (l == 0 || sync) ctx(l, tx_clock_lane_a);
  always @(tco) if (run) for (int l = 1; l < 4; l++) ctx(l, tco);
  always @(rx_clock_lane_a) if (run && sync) for (int l = 0; l < 3; l++) crx(l);
  always @(rco) if (run) for (int l = 0; l < 3; l++) crx(l);
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt > 8000) begin
      err_total++;
      report_and_stop();
    end
    if (wb_ack_o === 1'b1) begin
      nt = q.pop_front();
      if (nt[32]) chk(wb_dat_o, nt[31:0]);
    end
  end
  initial begin
    // Reset rises at time zero so the link-side toggles see its edge
    rst_i <= 1'b1;
    void'($urandom(17606));
    rnd = $urandom;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, `QLP_ADDR_CTRL, '0, 32'(`QLP_CTRL_RESET));
    wb(1'b0, `QLP_ADDR_TXSEEN, '0, '0);
    wb(1'b1, `QLP_ADDR_CTRL, rnd, '0);
    wb(1'b0, `QLP_ADDR_CTRL, '0, rnd & 32'h3);
    wb(1'b1, 32'h10, rnd, '0);
    wb(1'b0, 32'h10, '0, '0);
    for (int m = 0; m < 4; m++) begin
      {code, sync} <= 2'(m);
      repeat (8) @(posedge clk_i);
      wb(1'b0, `QLP_ADDR_STATUS, '0, 32'(m));
      run <= 1'b1;
      repeat (600) @(posedge clk_i);
      run <= 1'b0;
      repeat (60) @(posedge clk_i);
      if (!sync) wb(1'b0, `QLP_ADDR_TXSEEN, '0, 32'hf);
      wb(1'b1, `QLP_ADDR_TXSEEN, 32'hf, '0);
      wb(1'b0, `QLP_ADDR_TXSEEN, '0, '0);
    end
    report_and_stop();
  end
endmodule : tb
